/* core/aefr_pkg.sv */
package aefr_pkg;

    // ==========================================================
    // frame offsets (byte offsets within the stacked frame)
    localparam logic [7:0] OFF_SSW = 8'h0C;
    localparam logic [7:0] OFF_RTE_LAST = 8'h0D;
    localparam logic [7:0] OFF_WRITEBACK_STATUS_THREE = 8'h0E;
    localparam logic [7:0] OFF_WRITEBACK_STATUS_TWO = 8'h10;
    localparam logic [7:0] OFF_WRITEBACK_STATUS_ONE = 8'h12;
    localparam logic [7:0] OFF_FA = 8'h14;
    localparam logic [7:0] OFF_WB3A = 8'h18;
    localparam logic [7:0] OFF_WRITEBACK_DATA_THREE = 8'h1C;
    localparam logic [7:0] OFF_WB2A = 8'h20;
    localparam logic [7:0] OFF_WRITEBACK_DATA_TWO = 8'h24;
    localparam logic [7:0] OFF_WRITEBACK_ADDRESS_ONE = 8'h28;
    localparam logic [7:0] OFF_WRITEBACK_DATA_ONE = 8'h2C;
    localparam logic [7:0] OFF_PD1 = 8'h30;
    localparam logic [7:0] OFF_PD2 = 8'h34;
    localparam logic [7:0] OFF_PD3 = 8'h38;

    // ==========================================================
    // wishbone register map
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STAT = 8'h04;
    localparam logic [7:0] REG_SSW = 8'h08;
    localparam logic [7:0] REG_WBS = 8'h0C;
    localparam logic [7:0] REG_FA = 8'h10;
    localparam logic [7:0] REG_WRITEBACK_ADDRESS_ONE = 8'h14;
    localparam logic [7:0] REG_WRITEBACK_DATA_ONE = 8'h18;
    localparam logic [7:0] REG_WRITEBACK_DATA_TWO = 8'h1C;
    localparam logic [7:0] REG_WRITEBACK_DATA_THREE = 8'h20;
    localparam logic [7:0] REG_PD0 = 8'h24;
    localparam logic [7:0] REG_RTE = 8'h34;
    localparam logic [7:0] REG_SP = 8'h38;

    // control bits
    localparam int CTRL_ARM = 0;
    localparam int CTRL_RTE_GO = 1;
    // rte status bits
    localparam int RTE_DONE = 0;
    localparam int RTE_PEND = 1;

    // ==========================================================
    // encodings
    localparam logic [1:0] TT_NORMAL = 2'h0;
    localparam logic [1:0] TT_LINE_MOVE = 2'h1;
    localparam logic [2:0] TM_PUSH = 3'h0;
    localparam logic [1:0] SZ_LONG = 2'h0;
    localparam logic [1:0] SZ_LINE = 2'h3;
    localparam logic RW_READ = 1'b1;
    localparam logic RW_WRITE = 1'b0;
    localparam logic [31:0] SP_ADVANCE = 32'h0000003C;
    localparam logic [3:0] CONT_MASK = 4'hF;
    localparam logic [3:0] CONT_MOVEM = 4'h1;
    localparam logic [7:0] PEND_ADJ = 8'h0D;

    typedef enum logic [2:0] {
        FK_NONE, FK_READ, FK_PUSH, FK_WRITE, FK_LMOVE, FK_PAGE
    } aefr_kind_t;

    typedef struct packed {
        logic [3:0] cont;
        logic rw;
        logic [1:0] size;
        logic [1:0] tt;
        logic [2:0] tm;
    } aefr_ssw_t;

    typedef struct packed {
        logic valid;
        logic [1:0] tt;
        logic [1:0] size;
    } aefr_wbs_t;

    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] data;
        logic [1:0] tt;
        logic [1:0] size;
        logic valid;
    } aefr_slot_t;

endpackage

/* core/aefr_classify.sv */
`timescale 1ns/1ps
module aefr_classify
    import aefr_pkg::*;
(
    input wire logic is_push,
    input wire logic is_write,
    input wire logic is_page,
    input wire logic [1:0] tt,
    output aefr_kind_t kind
);
    // ==========================================================
    // fault classification
    always_comb begin
        if (is_page) begin
            kind = FK_PAGE;
        end else if (is_push) begin
            kind = FK_PUSH;
        end else if (!is_write) begin
            kind = FK_READ;
        end else if (tt == TT_LINE_MOVE) begin
            kind = FK_LMOVE;
        end else begin
            kind = FK_WRITE;
        end
    end
endmodule

/* core/aefr_wb_slave.sv */
`timescale 1ns/1ps
module aefr_wb_slave
    import aefr_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic cyc,
    input wire logic stb,
    input wire logic we,
    input wire logic [7:0] adr,
    output logic ack_ff,
    output logic wr_pulse,
    output logic [7:0] adr_q
);
    // ==========================================================
    // single cycle answer, ack dropped the cycle after
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= cyc && stb && !ack_ff;
        end
    end

    // write lands at the edge where the master sees ack high
    assign wr_pulse = cyc && stb && we && ack_ff;
    assign adr_q = adr;
endmodule

/* core/aefr_top.sv */
// Design decisions made here: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ps
// Notes on behaviour
// - read error: logical address, slots one/two cleared, only slot three
// - push error: physical address recorded, slot one ignored
// - push: all four long words saved, size line or long word
// - long-word push: address bits 3:2 pick the saved word
// - normal write error: logical address, slot one valid at address
// - line-move write error: logical address, slot one valid, four words
// - page fault: slot one clear, slot two valid, slot three and all four long words saved
// - push marked by transfer type 00 and modifier 000
// - slot line-move flagged by transfer type 01 with valid bit
// - slot three never line-move and never line size
// - return reads only frame offsets 0 through D
// - pending continuation: adjust stack, start that exception at once
// - read fault holds no pending writes in slots one or two
// - push frame never has slot one valid
// - no slot three write while slot two holds line-move, except page faults with pending slot two not valid
// - outside page faults, slot two line-move pending implies its read hit in cache
// - read/write flag: 1 read, 0 write
// - plain return advances stack pointer by 30 words
module aefr_top
    import aefr_pkg::*;
(
    // clock and reset
    input wire logic SYS_CLK,
    input wire logic RST_N,
    // wishbone slave
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [7:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    // fault report from the memory pipeline
    input wire logic FAULT_TAKE,
    input wire logic FAULT_PAGE,
    input wire logic FAULT_PUSH,
    input wire logic FAULT_WRITE,
    input wire logic FAULT_CACHE_HIT,
    input wire logic [1:0] FAULT_TT,
    input wire logic [2:0] FAULT_TM,
    input wire logic [1:0] FAULT_SIZE,
    input wire logic [31:0] FAULT_LOG_ADDR,
    input wire logic [31:0] FAULT_PHYS_ADDR,
    input wire logic [127:0] FAULT_LINE,
    input aefr_pkg::aefr_slot_t PEND_SLOT1,
    input aefr_pkg::aefr_slot_t PEND_SLOT2,
    input aefr_pkg::aefr_slot_t PEND_SLOT3,
    // exception resume
    output logic FRAME_READY,
    output logic PEND_EXC_START,
    output logic RESUME
);
    import aefr_pkg::*;

    // ==========================================================
    // bus slave
    logic wb_ack;
    logic wb_wr;
    logic [7:0] wb_adr;
    aefr_wb_slave u_wb (
        .clk(SYS_CLK),
        .rst_n(RST_N),
        .cyc(WB_CYC_I),
        .stb(WB_STB_I),
        .we(WB_WE_I),
        .adr(WB_ADR_I),
        .ack_ff(wb_ack),
        .wr_pulse(wb_wr),
        .adr_q(wb_adr)
    );
    assign WB_ACK_O = wb_ack;

    // ==========================================================
    // classification
    aefr_kind_t kind;
    aefr_classify u_cls (
        .is_push(FAULT_PUSH),
        .is_write(FAULT_WRITE),
        .is_page(FAULT_PAGE),
        .tt(FAULT_TT),
        .kind(kind)
    );

    // ==========================================================
    // frame record
    logic arm_ff;
    logic ready_ff;
    aefr_ssw_t ssw_ff;
    logic [31:0] fa_ff;
    aefr_slot_t s1_ff, s2_ff, s3_ff;
    logic [31:0] pd_ff [4];
    logic [3:0] cont_ff;
    logic [31:0] sp_ff;
    logic take;

    assign take = FAULT_TAKE && arm_ff;

    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            arm_ff <= 1'b0;
        end else if (wb_wr && wb_adr == REG_CTRL && WB_SEL_I[0]) begin
            arm_ff <= WB_DAT_I[CTRL_ARM];
        end
    end

    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            ready_ff <= 1'b0;
        end else if (take) begin
            ready_ff <= 1'b1;
        end else if (wb_wr && wb_adr == REG_RTE && WB_DAT_I[CTRL_RTE_GO]) begin
            ready_ff <= 1'b0;
        end
    end

    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            ssw_ff <= '0;
        end else if (take) begin
            ssw_ff.rw <= (kind == FK_READ) ? RW_READ : RW_WRITE;
            ssw_ff.tt <= (kind == FK_PUSH) ? TT_NORMAL : FAULT_TT;
            ssw_ff.tm <= (kind == FK_PUSH) ? TM_PUSH : FAULT_TM;
            ssw_ff.size <= (kind == FK_PUSH && FAULT_SIZE != SZ_LINE)
                ? SZ_LONG : FAULT_SIZE;
            ssw_ff.cont <= '0;
        end else if (wb_wr && wb_adr == REG_SSW) begin
            ssw_ff.cont <= WB_DAT_I[11:8];
        end
    end

    // physical for push keeps bits 3:2
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            fa_ff <= '0;
        end else if (take) begin
            fa_ff <= (kind == FK_PUSH) ? FAULT_PHYS_ADDR : FAULT_LOG_ADDR;
        end
    end

    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            s1_ff <= '0;
        end else if (take) begin
            s1_ff <= '0;
            if (kind == FK_WRITE || kind == FK_LMOVE) begin
                s1_ff.valid <= 1'b1;
                s1_ff.addr <= FAULT_LOG_ADDR;
                s1_ff.data <= PEND_SLOT1.data;
                s1_ff.size <= FAULT_SIZE;
                s1_ff.tt <= (kind == FK_LMOVE) ? TT_LINE_MOVE : TT_NORMAL;
            end
        end
    end

    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            s2_ff <= '0;
        end else if (take) begin
            if (kind == FK_READ) begin
                s2_ff <= '0;
            end else if (kind == FK_PAGE) begin
                s2_ff <= PEND_SLOT2;
                s2_ff.valid <= 1'b1;
            end else begin
                s2_ff <= PEND_SLOT2;
                if (PEND_SLOT2.tt == TT_LINE_MOVE && !FAULT_CACHE_HIT) begin
                    s2_ff.valid <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            s3_ff <= '0;
        end else if (take) begin
            s3_ff <= PEND_SLOT3;
            s3_ff.tt <= TT_NORMAL;
            if (PEND_SLOT3.size == SZ_LINE) begin
                s3_ff.size <= SZ_LONG;
            end
            if (kind != FK_READ && PEND_SLOT2.valid
                && PEND_SLOT2.tt == TT_LINE_MOVE) begin
                s3_ff.valid <= 1'b0;
            end
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_pd
            always_ff @(posedge SYS_CLK or negedge RST_N) begin
                if (!RST_N) begin
                    pd_ff[gi] <= '0;
                end else if (take && (kind == FK_PUSH || kind == FK_LMOVE
                                      || kind == FK_PAGE)) begin
                    pd_ff[gi] <= FAULT_LINE[gi*32 +: 32];
                end
            end
        end
    endgenerate

    // ==========================================================
    // return from exception
    // only offsets up to D consumed
    assign cont_ff = ssw_ff.cont & CONT_MASK;

    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            sp_ff <= '0;
            RESUME <= 1'b0;
            PEND_EXC_START <= 1'b0;
        end else begin
            RESUME <= 1'b0;
            PEND_EXC_START <= 1'b0;
            if (wb_wr && wb_adr == REG_SP) begin
                sp_ff <= WB_DAT_I;
            end else if (wb_wr && wb_adr == REG_RTE
                         && WB_DAT_I[CTRL_RTE_GO] && ready_ff) begin
                sp_ff <= sp_ff + SP_ADVANCE;
                if (cont_ff != 4'h0 && cont_ff != CONT_MOVEM) begin
                    PEND_EXC_START <= 1'b1;
                end else begin
                    RESUME <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            FRAME_READY <= 1'b0;
        end else begin
            FRAME_READY <= ready_ff;
        end
    end

    // ==========================================================
    // read data
    logic [31:0] rd;
    always_comb begin
        rd = '0;
        unique case (wb_adr)
            REG_CTRL: rd = {31'h0, arm_ff};
            REG_STAT: rd = {31'h0, ready_ff};
            REG_SSW: rd = {20'h0, ssw_ff};
            REG_WBS: rd = {17'h0, s3_ff.valid, s3_ff.tt, s3_ff.size,
                           s2_ff.valid, s2_ff.tt, s2_ff.size,
                           s1_ff.valid, s1_ff.tt, s1_ff.size};
            REG_FA: rd = fa_ff;
            REG_WRITEBACK_ADDRESS_ONE: rd = s1_ff.addr;
            REG_WRITEBACK_DATA_ONE: rd = s1_ff.data;
            REG_WRITEBACK_DATA_TWO: rd = s2_ff.data;
            REG_WRITEBACK_DATA_THREE: rd = s3_ff.data;
            8'h24: rd = pd_ff[0];
            8'h28: rd = pd_ff[1];
            8'h2C: rd = pd_ff[2];
            8'h30: rd = pd_ff[3];
            REG_SP: rd = sp_ff;
            default: rd = '0;
        endcase
    end

    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            WB_DAT_O <= '0;
        end else if (WB_CYC_I && WB_STB_I && !wb_ack) begin
            WB_DAT_O <= rd;
        end
    end

    // ==========================================================
    // checks
    read_clear_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        take && kind == FK_READ |=> !s1_ff.valid && !s2_ff.valid)
        else $error("read fault left slot one or two valid");
    push_phys_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        take && kind == FK_PUSH |=> fa_ff == $past(FAULT_PHYS_ADDR))
        else $error("push fault address not physical");
    push_one_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        ssw_ff.tm == TM_PUSH && ssw_ff.tt == TT_NORMAL && ready_ff
        |-> !s1_ff.valid)
        else $error("push frame has slot one valid");
    write_one_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        take && kind == FK_WRITE |=> s1_ff.valid
        && s1_ff.addr == fa_ff)
        else $error("write slot one mismatch");
    page_two_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        take && kind == FK_PAGE |=> s2_ff.valid && !s1_ff.valid)
        else $error("page fault slots wrong");
    three_line_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        s3_ff.tt != TT_LINE_MOVE && s3_ff.size != SZ_LINE)
        else $error("slot three holds line move");
    rw_code_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        take |=> ssw_ff.rw == ($past(kind) == FK_READ))
        else $error("read write flag wrong");
    sp_step_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        RESUME || PEND_EXC_START |-> sp_ff == $past(sp_ff) + 32'h3C)
        else $error("stack not advanced by thirty words");
endmodule

/* testbench/aefr_mem_model.sv */
`timescale 1ns/1ps
module aefr_mem_model
    import aefr_pkg::*;
(
    // clock
    input wire logic clk,
    // fault report: qual is {page,push,write,hit}, attr is {tt,tm,size}
    output logic take,
    output logic [3:0] qual,
    output logic [6:0] attr,
    output logic [31:0] log_a,
    output logic [31:0] phys_a,
    output logic [127:0] line,
    // pending write-backs
    output aefr_slot_t s1,
    output aefr_slot_t s2,
    output aefr_slot_t s3
);
    initial begin
        {take, qual, attr, log_a, phys_a, line, s1, s2, s3} = '0;
    end

    // ==========================================================
    // one fault, entered right after a rising edge
    task automatic fire(input logic [3:0] q, input logic [6:0] at,
        input logic [31:0] la, input logic [31:0] pa,
        input logic [127:0] ln, input aefr_slot_t a,
        input aefr_slot_t b, input aefr_slot_t c);
        take <= 1'b1;
        qual <= q;
        attr <= at;
        log_a <= la;
        phys_a <= pa;
        line <= ln;
        s1 <= a;
        s2 <= b;
        s3 <= c;
        @(posedge clk);
        take <= 1'b0;
        // fields move on
        // pipeline moves on at once; only the take edge may be captured
        qual <= ~q;
        attr <= ~at;
        log_a <= ~la;
        phys_a <= ~pa;
        line <= ~ln;
        s1 <= ~a;
        s2 <= ~b;
        s3 <= ~c;
    endtask
endmodule

/* testbench/aefr_top_tb.sv */
`timescale 1ns/1ps
module aefr_top_tb;
    import aefr_pkg::*;

    // ==========================================================
    // clock, reset and bus
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic ack;
    logic fr;
    logic pend_x;
    logic resm;
    logic take;
    logic [3:0] qual;
    logic [6:0] attr;
    logic [31:0] log_a;
    logic [31:0] phys_a;
    logic [127:0] line;
    aefr_slot_t s1;
    aefr_slot_t s2;
    aefr_slot_t s3;
    string q_nm[$];
    logic [31:0] q_ex[$];
    int n_errors = 0;
    int checks_done = 0;
    int n_res = 0;
    int n_pend = 0;
    int cycles = 0;

    initial begin
        forever #10 sys_clk = ~sys_clk;
    end

    aefr_mem_model mem (.clk(sys_clk), .take(take), .qual(qual),
        .attr(attr), .log_a(log_a), .phys_a(phys_a), .line(line),
        .s1(s1), .s2(s2), .s3(s3));

    aefr_top DUT (.SYS_CLK(sys_clk), .RST_N(rst_n), .WB_CYC_I(cyc),
        .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel),
        .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
        .FAULT_TAKE(take), .FAULT_PAGE(qual[3]), .FAULT_PUSH(qual[2]),
        .FAULT_WRITE(qual[1]), .FAULT_CACHE_HIT(qual[0]),
        .FAULT_TT(attr[6:5]), .FAULT_TM(attr[4:2]), .FAULT_SIZE(attr[1:0]),
        .FAULT_LOG_ADDR(log_a), .FAULT_PHYS_ADDR(phys_a),
        .FAULT_LINE(line), .PEND_SLOT1(s1), .PEND_SLOT2(s2),
        .PEND_SLOT3(s3), .FRAME_READY(fr), .PEND_EXC_START(pend_x),
        .RESUME(resm));

    // ==========================================================
    // reporting
    task automatic conclude();
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic check(input string nm, input logic [31:0] got,
        input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // read results are judged here against the oldest note
    always @(posedge sys_clk) begin
        cycles++;
        if (resm === 1'b1) n_res++;
        if (pend_x === 1'b1) n_pend++;
        if (cyc && stb && !we && ack === 1'b1 && q_ex.size() > 0) begin
            check(q_nm.pop_front(), rdat, q_ex.pop_front());
        end
        if (cycles == 20000) begin
            n_errors++;
            conclude();
        end
    end

    // ==========================================================
    // wishbone classic single cycle
    task automatic wb(input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= 4'hF;
        @(posedge sys_clk);
        while (ack !== 1'b1 && n < 50) begin
            @(posedge sys_clk);
            n++;
        end
        if (n == 50) n_errors++;
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e,
        input string nm);
        logic [31:0] t;
        q_ex.push_back(e);
        q_nm.push_back(nm);
        wb(1'b0, a, 32'h0, t);
    endtask

    // ==========================================================
    // k: 0 read, 1 line push, 2 long push, 3 write, 4 line move, 5 page
    task automatic run_fault(input int k);
        logic [31:0] la, pa, sp0, t;
        logic [127:0] ln;
        logic [3:0] q, cn;
        logic [1:0] ty, sz;
        logic [2:0] tm;
        logic rw;
        aefr_slot_t a, b, c;
        aefr_wbs_t e1, e2, e3;
        int n, r0, p0;
        la = $urandom();
        pa = $urandom();
        ln = {$urandom(), $urandom(), $urandom(), $urandom()};
        q = 4'b0010;
        ty = TT_NORMAL;
        tm = 3'h5;
        sz = SZ_LONG;
        b = '{$urandom(), $urandom(), TT_NORMAL, SZ_LONG, 1'b1};
        c = '{$urandom(), $urandom(), TT_NORMAL, SZ_LONG, 1'b1};
        case (k)
            0: begin q = 4'b0000; tm = 3'h1; end
            1: begin q = 4'b0110; tm = TM_PUSH; sz = SZ_LINE; end
            2: begin q = 4'b0110; tm = TM_PUSH; b.valid = 0; c.valid = 0; end
            3: begin q = 4'b0011; b.tt = TT_LINE_MOVE; end
            4: begin ty = TT_LINE_MOVE; sz = SZ_LINE; b.tt = ty; c.valid = 0; end
            default: q = 4'b1010;
        endcase
        a = '{la, $urandom(), ty, sz, 1'b1};
        e1 = '0;
        e2 = '{b.valid, b.tt, b.size};
        e3 = '{c.valid, c.tt, c.size};
        if (k == 3 || k == 4) e1 = '{1'b1, ty, sz};
        if (k == 0 || k == 2) e2 = '0;
        // line move without a cache hit is dropped from slot two
        if (k == 4) e2.valid = 1'b0;
        if (k >= 2 && k <= 4) e3 = '0;
        rw = (k == 0) ? RW_READ : RW_WRITE;
        wb(1'b1, REG_CTRL, 32'h1, t);
        mem.fire(q, {ty, tm, sz}, la, pa, ln, a, b, c);
        n = 0;
        while (fr !== 1'b1 && n < 10) begin
            @(posedge sys_clk);
            n++;
        end
        rd(REG_STAT, 32'h1, "stat");
        rd(REG_SSW, {20'h0, 4'h0, rw, sz, ty, tm}, "ssw");
        if (k < 5) rd(REG_FA, (k == 1 || k == 2) ? pa : la, "fa");
        rd(REG_WBS, {17'h0, e3, e2, e1}, "wbs");
        if (k == 3) rd(REG_WRITEBACK_ADDRESS_ONE, la, "writeback_address_one");
        if (k == 1 || k == 2 || k == 4) begin
            for (n = 0; n < 4; n++) begin
                rd(REG_PD0 + 8'(4 * n), ln[32 * n +: 32], "pd");
            end
        end
        cn = (k == 5) ? 4'h2 : (k == 3) ? CONT_MOVEM : 4'h0;
        wb(1'b1, REG_SSW, {20'h0, cn, 8'h00}, t);
        wb(1'b0, REG_SP, 32'h0, sp0);
        r0 = n_res;
        p0 = n_pend;
        wb(1'b1, REG_RTE, 32'h2, t);
        repeat (3) @(posedge sys_clk);
        check("resume", 32'(n_res - r0), (cn == 4'h2) ? 32'h0 : 32'h1);
        check("pend", 32'(n_pend - p0), (cn == 4'h2) ? 32'h1 : 32'h0);
        rd(REG_STAT, 32'h0, "stat");
        rd(REG_SP, sp0 + SP_ADVANCE, "sp");
    endtask

    // ==========================================================
    // main sequence
    initial begin
        logic [31:0] t;
        void'($urandom(41));
        repeat (12) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        rd(REG_CTRL, 32'h0, "ctrl");
        rd(REG_STAT, 32'h0, "stat");
        // unarmed capture must not open a frame
        mem.fire(4'h2, 7'h04, $urandom(), $urandom(), '0, '0, '0, '0);
        repeat (4) @(posedge sys_clk);
        rd(REG_STAT, 32'h0, "unarmed");
        rd(8'h3C, 32'h0, "unmapped");
        wb(1'b1, 8'h40, $urandom(), t);
        rd(8'h40, 32'h0, "unmapped");
        for (int k = 0; k < 6; k++) begin
            run_fault(k);
        end
        conclude();
    end
endmodule
